// ===== src/pwg_pkg.sv
// Constants, register map and carrier types of the PWM/PDM channel generator.
// Assumes a 40 MHz system clock and a plain single-cycle register port.
// How it works
// RULE_01: Disabled channel holds every output low.
// RULE_02: Duty equals value over scale plus offset.
// RULE_03: Magnitude limited by floor/ceiling; duty reported signed.
// RULE_04: Waveform pin only in types 0 and 1.
// RULE_05: Type 1 direction low forward, high reverse.
// RULE_06: Type 2 routes waveform to up or down.
// RULE_07: Carrier frequency clamped to half strobe rate.
// RULE_08: Undithered period is whole number of ticks.
// RULE_09: Zero carrier frequency selects pulse density.
// RULE_10: Undithered duty rounds to nearest tick count.
// RULE_11: Dithering alternates between two nearest counts.
// RULE_12: Dither setting ignored in pulse density mode.
// RULE_13: Type 0 negative duty gives floor duty.
// RULE_14: Slow update step precomputes; fast strobe generates.
// RULE_15: Density mode: accumulator overflow asserts output.
// RULE_16: Settings are signed fixed point, sampled at update; freq is unsigned Hz, and enable and output type act at once.
package pwg_pkg;

  // Timing
  localparam int unsigned CLK_NS    = 25;     // System clock period
  localparam int unsigned TICK_NS   = 1000;   // Pulse strobe period
  localparam int unsigned UPDATE_NS = 100000; // Update step period
  localparam int unsigned TICK_CYC  = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned UPD_CYC   = (UPDATE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned TICK_HZ   = 1000000000 / TICK_NS;
  localparam int unsigned DIV_STEPS = 32;     // Divider iterations

  // Fixed point: Q2.14, 1.0 is 16'h4000
  localparam int unsigned FRAC_BITS = 14;
  localparam logic [14:0] DUTY_ONE  = 15'h4000;
  localparam logic [35:0] HALF_LSB  = 36'h000002000;

  // Register word addresses
  localparam logic [3:0] ADDR_CTRL    = 4'h0;
  localparam logic [3:0] ADDR_VALUE   = 4'h1;
  localparam logic [3:0] ADDR_SCALE   = 4'h2;
  localparam logic [3:0] ADDR_OFFSET  = 4'h3;
  localparam logic [3:0] ADDR_FLOOR   = 4'h4;
  localparam logic [3:0] ADDR_CEILING = 4'h5;
  localparam logic [3:0] ADDR_FREQ    = 4'h6;
  localparam logic [3:0] ADDR_PRESENT = 4'h7;
  localparam logic [3:0] ADDR_PERIOD  = 4'h8;

  // Control field positions
  localparam int unsigned CTRL_EN     = 0;
  localparam int unsigned CTRL_DITHER = 1;
  localparam int unsigned CTRL_TYPE   = 2;

  // Values after reset
  localparam logic [3:0]  RST_CTRL    = 4'h0;
  localparam logic [15:0] RST_VALUE   = 16'h0000;
  localparam logic [15:0] RST_SCALE   = 16'h4000;
  localparam logic [15:0] RST_OFFSET  = 16'h0000;
  localparam logic [15:0] RST_FLOOR   = 16'h0000;
  localparam logic [15:0] RST_CEILING = 16'h4000;
  localparam logic [31:0] RST_FREQ    = 32'h000003e8;

  // Settings captured at each update step
  typedef struct packed {
    logic signed [15:0] value;
    logic signed [15:0] scale;
    logic signed [15:0] offset;
    logic signed [15:0] floor_dc;
    logic signed [15:0] ceiling_dc;
    logic [31:0]        freq;
    logic               dither;
  } pwg_set_type;

  // Counts handed from update step to pulse step
  typedef struct packed {
    logic [19:0] period; // Zero selects density mode
    logic [19:0] high;
    logic [13:0] frac;
    logic [14:0] mag;
    logic        dither;
  } pwg_cnt_type;

endpackage

// ===== src/pwg_channel.sv
// One PWM/PDM channel: register port, slow update step and fast pulse step.
// Assumes the register master is synchronous to clk and never strobes
// read and write together.
//
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/1ps

module pwg_channel
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Register port
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [31:0]      rdata,
  // Power stage pins
  output logic             pwm,
  output logic             dir,
  output logic             up,
  output logic             down
);

  // Magnitude of a signed 16-bit word
  function automatic logic [15:0] abs16(input logic signed [15:0] v);
    abs16 = v[15] ? 16'(-v) : 16'(v);
  endfunction

  // Limit a duty setting to the range 0 .. 1.0
  function automatic logic [14:0] lim_one(input logic signed [15:0] v);
    if (v[15])
      lim_one = 15'h0000;
    else if (v[14:0] > pwg_pkg::DUTY_ONE)
      lim_one = pwg_pkg::DUTY_ONE;
    else
      lim_one = v[14:0];
  endfunction

  // Update step sequencer
  typedef enum logic [1:0] {PWG_IDLE, PWG_DIV_DUTY, PWG_DIV_PER, PWG_FINISH} pwg_state_type;

  // Register file
  logic [3:0]         ctrl;        // Enable, dither, output type
  logic signed [15:0] value;       // Commanded value
  logic signed [15:0] scale;       // Value giving full duty
  logic signed [15:0] offset;      // Duty offset
  logic signed [15:0] duty_floor;  // Least duty magnitude
  logic signed [15:0] duty_ceiling;// Greatest duty magnitude
  logic [31:0]        freq;        // Requested carrier in Hz
  logic signed [15:0] present_duty;// Duty after limits

  // Clock enables
  logic [5:0]  tick_cnt;           // Pulse strobe divider
  logic [11:0] upd_cnt;            // Update step divider
  logic        tick;               // Pulse strobe
  logic        upd;                // Update step strobe

  // Update step state
  pwg_state_type      state;
  pwg_pkg::pwg_set_type snap;       // Settings sampled at update
  pwg_pkg::pwg_cnt_type next_cnt;   // Counts being built
  pwg_pkg::pwg_cnt_type cnt_set;    // Counts for pulse step
  logic [31:0]        num;         // Dividend, becomes quotient
  logic [31:0]        den;         // Divisor
  logic [31:0]        rem;         // Partial remainder
  logic [5:0]         steps;       // Divider steps left
  logic [16:0]        quo;         // Saturated duty quotient
  logic               q_neg;       // Quotient sign

  // Pulse step state
  pwg_pkg::pwg_cnt_type live;       // Counts of running period
  logic [19:0]        pos;         // Tick within period
  logic [19:0]        cur_high;    // High ticks this period
  logic [13:0]        facc;        // Dither fraction accumulator
  logic [13:0]        dacc;        // Density accumulator
  logic               wave;        // Raw waveform
  logic               neg;         // Reverse direction

  // Register decode
  wire        sel_w = wr && (addr <= pwg_pkg::ADDR_FREQ);
  wire [1:0]  otype = ctrl[pwg_pkg::CTRL_TYPE +: 2];
  wire        en    = ctrl[pwg_pkg::CTRL_EN];
  wire [31:0] rd_mux =
    (addr == pwg_pkg::ADDR_CTRL)    ? {28'h0000000, ctrl} :
    (addr == pwg_pkg::ADDR_VALUE)   ? {{16{value[15]}}, value} :
    (addr == pwg_pkg::ADDR_SCALE)   ? {{16{scale[15]}}, scale} :
    (addr == pwg_pkg::ADDR_OFFSET)  ? {{16{offset[15]}}, offset} :
    (addr == pwg_pkg::ADDR_FLOOR)   ? {{16{duty_floor[15]}}, duty_floor} :
    (addr == pwg_pkg::ADDR_CEILING) ? {{16{duty_ceiling[15]}}, duty_ceiling} :
    (addr == pwg_pkg::ADDR_FREQ)    ? freq :
    (addr == pwg_pkg::ADDR_PRESENT) ? {{16{present_duty[15]}}, present_duty} :
    (addr == pwg_pkg::ADDR_PERIOD)  ? {12'h000, cnt_set.period} :
    32'h00000000;

  // Divider trial subtraction, one quotient bit per cycle
  wire [32:0] trial    = {rem, num[31]} - {1'b0, den};
  wire        trial_ok = !trial[32];

  // Duty arithmetic on the finished quotient
  wire signed [19:0] q_s   = q_neg ? -$signed({3'b000, quo}) : $signed({3'b000, quo});
  wire signed [19:0] dc    = q_s + 20'(snap.offset);                      // RULE_02
  wire               dc_neg = dc[19];
  wire [19:0]        dc_abs = dc_neg ? 20'(-dc) : 20'(dc);
  wire [14:0]        lo     = lim_one(snap.floor_dc);
  wire [14:0]        hi     = lim_one(snap.ceiling_dc);
  // Floor applied first so a ceiling below the floor still wins
  wire [14:0] m_floor = (dc_abs < {5'h00, lo}) ? lo : dc_abs[14:0];     // RULE_03
  wire [14:0] m_lim   = (dc_abs > {5'h00, hi} || m_floor > hi) ? hi : m_floor; // RULE_03
  wire [14:0] m_used  = (dc_neg && otype == 2'h0) ? lo : m_lim;         // RULE_13

  // High tick counts from magnitude and period
  wire [35:0] prod     = 36'(m_used) * 36'(next_cnt.period);
  wire [35:0] prod_rnd = prod + pwg_pkg::HALF_LSB;
  wire [31:0] half_hz  = 32'(pwg_pkg::TICK_HZ / 2);
  wire [31:0] tick_hz  = 32'(pwg_pkg::TICK_HZ);

  // Dither and density accumulator sums, and the last tick of the running period
  wire [14:0] facc_sum = {1'b0, facc} + {1'b0, cnt_set.frac};
  wire [14:0] dacc_sum = {1'b0, dacc} + live.mag;
  wire        last     = (pos + 20'h00001 >= live.period);

  // Strobe dividers; update is much slower than the pulse strobe
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      tick_cnt <= 6'h00;
      upd_cnt  <= 12'h000;
    end
    else
    begin
      tick_cnt <= (tick_cnt == 6'(pwg_pkg::TICK_CYC - 1)) ? 6'h00 : tick_cnt + 6'h01;
      upd_cnt  <= (upd_cnt == 12'(pwg_pkg::UPD_CYC - 1)) ? 12'h000 : upd_cnt + 12'h001;
    end
  end

  assign tick = (tick_cnt == 6'h00);
  assign upd  = (upd_cnt == 12'h000);

  // Register writes and read data, answered the cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctrl         <= pwg_pkg::RST_CTRL;
      value        <= pwg_pkg::RST_VALUE;
      scale        <= pwg_pkg::RST_SCALE;
      offset       <= pwg_pkg::RST_OFFSET;
      duty_floor   <= pwg_pkg::RST_FLOOR;
      duty_ceiling <= pwg_pkg::RST_CEILING;
      freq         <= pwg_pkg::RST_FREQ;
      rdata        <= 32'h00000000;
    end
    else
    begin
      if (sel_w && addr == pwg_pkg::ADDR_CTRL)
        ctrl <= wdata[3:0];
      if (sel_w && addr == pwg_pkg::ADDR_VALUE)
        value <= wdata[15:0];
      if (sel_w && addr == pwg_pkg::ADDR_SCALE)
        scale <= wdata[15:0];
      if (sel_w && addr == pwg_pkg::ADDR_OFFSET)
        offset <= wdata[15:0];
      if (sel_w && addr == pwg_pkg::ADDR_FLOOR)
        duty_floor <= wdata[15:0];
      if (sel_w && addr == pwg_pkg::ADDR_CEILING)
        duty_ceiling <= wdata[15:0];
      if (sel_w && addr == pwg_pkg::ADDR_FREQ)
        freq <= wdata;
      // Unmapped reads return zero
      rdata <= rd ? rd_mux : 32'h00000000;
    end
  end

  // Slow update step: sample, divide twice, derive counts
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state        <= PWG_IDLE;
      snap         <= '0;
      next_cnt     <= '0;
      cnt_set      <= '0;
      num          <= 32'h00000000;
      den          <= 32'h00000000;
      rem          <= 32'h00000000;
      steps        <= 6'h00;
      quo          <= 17'h00000;
      q_neg        <= 1'b0;
      present_duty <= 16'h0000;
    end
    else
    begin
      unique case (state)
        PWG_IDLE:
        begin
          if (upd)
          begin
            // Settings other than enable and output type are only looked at here
            snap  <= '{value, scale, offset, duty_floor, duty_ceiling, freq,
                       ctrl[pwg_pkg::CTRL_DITHER]};                     // RULE_16
            num   <= {2'b00, abs16(value), 14'h0000};
            den   <= {16'h0000, abs16(scale)};
            rem   <= 32'h00000000;
            steps <= 6'(pwg_pkg::DIV_STEPS);
            q_neg <= value[15] ^ scale[15];
            state <= PWG_DIV_DUTY;                                      // RULE_14
          end
        end
        PWG_DIV_DUTY, PWG_DIV_PER:
        begin
          if (steps != 6'h00)
          begin
            rem   <= trial_ok ? trial[31:0] : {rem[30:0], num[31]};
            num   <= {num[30:0], trial_ok};
            steps <= steps - 6'h01;
          end
          else if (state == PWG_DIV_DUTY)
          begin
            // Zero scale divides to all ones and saturates
            quo   <= (num[31:17] != 15'h0000) ? 17'h1ffff : num[16:0];
            // Undithered carrier rounds to nearest whole period
            num   <= snap.dither ? tick_hz : tick_hz + (snap.freq >> 1); // RULE_08
            den   <= snap.freq;
            rem   <= 32'h00000000;
            steps <= 6'(pwg_pkg::DIV_STEPS);
            state <= PWG_DIV_PER;
          end
          else
          begin
            if (snap.freq == 32'h00000000)
              next_cnt.period <= 20'h00000;                             // RULE_09
            else if (snap.freq > half_hz)
              next_cnt.period <= 20'h00002;                             // RULE_07
            else
              next_cnt.period <= (num[31:20] != 12'h000) ? 20'hfffff : num[19:0];
            state <= PWG_FINISH;
          end
        end
        PWG_FINISH:
        begin
          cnt_set.period  <= next_cnt.period;
          cnt_set.mag     <= m_used;
          cnt_set.frac    <= prod[13:0];
          // Dither means nothing without a period
          cnt_set.dither  <= snap.dither && (next_cnt.period != 20'h00000); // RULE_12
          cnt_set.high    <= snap.dither ? prod[33:14] : prod_rnd[33:14];  // RULE_10
          present_duty    <= dc_neg ? -$signed({1'b0, m_used}) : $signed({1'b0, m_used}); // RULE_03
          state           <= PWG_IDLE;
        end
      endcase
    end
  end

  // Fast pulse step; new counts are taken at a period boundary, or on every tick in density mode
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      live     <= '0;
      pos      <= 20'h00000;
      cur_high <= 20'h00000;
      facc     <= 14'h0000;
      dacc     <= 14'h0000;
      wave     <= 1'b0;
      neg      <= 1'b0;
    end
    else if (tick)
    begin
      if (live.period == 20'h00000)
      begin
        // Density mode: overflow of the accumulator gives a high tick
        dacc <= dacc_sum[13:0];                                         // RULE_15
        wave <= dacc_sum[14];                                           // RULE_15
        live <= cnt_set;
        neg  <= present_duty[15];
        pos  <= 20'h00000;
      end
      else
      begin
        wave <= (pos < cur_high);
        if (last)
        begin
          // Swap in fresh counts and pick this period's duty
          live <= cnt_set;                                              // RULE_14
          neg  <= present_duty[15];
          pos  <= 20'h00000;
          if (cnt_set.dither)
          begin
            facc     <= facc_sum[13:0];                                  // RULE_11
            cur_high <= cnt_set.high + 20'(facc_sum[14]);               // RULE_11
          end
          else
            cur_high <= cnt_set.high;                                   // RULE_10
        end
        else
          pos <= pos + 20'h00001;
      end
    end
  end

  // Output pins per output type, all low while disabled
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pwm  <= 1'b0;
      dir  <= 1'b0;
      up   <= 1'b0;
      down <= 1'b0;
    end
    else
    begin
      pwm  <= en && (otype == 2'h0 || otype == 2'h1) && wave;           // RULE_01 RULE_04
      dir  <= en && (otype == 2'h1) && neg;                             // RULE_05
      up   <= en && (otype == 2'h2) && wave && !neg;                    // RULE_06
      down <= en && (otype == 2'h2) && wave && neg;                     // RULE_06
    end
  end

endmodule

// ===== verif/pwg_channel_properties.sv
// Concurrent checks on the channel's register port and power stage pins.
// Assumes it is bound to pwg_channel and sees only that module's ports.
`timescale 1ns/1ps

module pwg_channel_properties
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Register port
  input wire logic [3:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  // Power stage pins
  input wire logic        pwm,
  input wire logic        dir,
  input wire logic        up,
  input wire logic        down
);
  logic [3:0]       ctrl_q;                                      // Shadow of the control register
  logic [7:0]       quiet;                                       // Clocks since a control write
  logic [7:0]       run_len;                                     // Clocks pwm has held its level
  wire logic        ctrl_wr = wr && (addr == pwg_pkg::ADDR_CTRL); // Control write seen
  wire logic [1:0]  typ     = ctrl_q[3:2];                       // Selected output type
  wire logic        settled = quiet >= 8'd2;                     // Mode change has reached pins

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Follow control writes; pins lag a write by one clock
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctrl_q <= 4'h0;
      quiet  <= 8'h00;
    end
    else if (ctrl_wr)
    begin
      ctrl_q <= wdata[3:0];
      quiet  <= 8'h00;
    end
    else if (quiet != 8'hff)
      quiet <= quiet + 8'h01; // Saturate, long runs stay settled
  end

  // Length of the present pwm level, saturating
  always_ff @(posedge clk)
  begin
    if (rst)
      run_len <= 8'h00;
    else if ($changed(pwm))
      run_len <= 8'h01;
    else if (run_len != 8'hff)
      run_len <= run_len + 8'h01;
  end

  // Write to a register, then read it back two clocks later
  sequence s_wr_rd(logic [3:0] a);
    (wr && addr == a) ##2 (rd && addr == a);
  endsequence

  property p_rdata_idle;
    !$past(rd) |-> rdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero outside answer");

  property p_reserved;
    rd && addr >= 4'h9 |=> rdata == 32'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("unmapped read not zero");

  property p_ctrl_back;
    s_wr_rd(pwg_pkg::ADDR_CTRL) |=> rdata == {28'h0, $past(wdata[3:0], 3)};
  endproperty
  a_ctrl_back: assert property (p_ctrl_back) else $error("control readback wrong");

  property p_value_back;
    s_wr_rd(pwg_pkg::ADDR_VALUE) |=> rdata == {{16{$past(wdata[15], 3)}}, $past(wdata[15:0], 3)};
  endproperty
  a_value_back: assert property (p_value_back) else $error("value readback not sign extended");

  property p_off;
    settled && !ctrl_q[0] |-> !(pwm || dir || up || down);
  endproperty
  a_off: assert property (p_off) else $error("pin high while disabled");

  property p_type01;
    settled && typ < 2'd2 |-> !up && !down;
  endproperty
  a_type01: assert property (p_type01) else $error("up or down active in type 0 or 1");

  property p_type2;
    settled && typ[1] |-> !pwm && !dir;
  endproperty
  a_type2: assert property (p_type2) else $error("pwm or dir active in type 2");

  property p_dir;
    settled && typ != 2'd1 |-> !dir;
  endproperty
  a_dir: assert property (p_dir) else $error("dir active outside type 1");

  property p_updown;
    up |-> !down;
  endproperty
  a_updown: assert property (p_updown) else $error("up and down high together");

  property p_hold;
    quiet >= 8'd200 && $changed(pwm) |-> run_len >= 8'd40;
  endproperty
  a_hold: assert property (p_hold) else $error("pwm level shorter than one tick");
endmodule

bind pwg_channel pwg_channel_properties i_props (
  .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .pwm(pwm), .dir(dir), .up(up), .down(down)
);

// ===== verif/pwg_stage_model.sv
// Power stage model: counts clocks each gate input is driven on.
// Assumes the bench clears it before each measurement window.
`timescale 1ns/1ps

module pwg_stage_model
(
  // Clock and clear
  input  wire logic clk,
  input  wire logic clr,
  // Gate inputs
  input  wire logic pwm,
  input  wire logic dir,
  input  wire logic up,
  input  wire logic down,
  // High clocks per gate
  output int        n_pwm,
  output int        n_dir,
  output int        n_up,
  output int        n_down
);
  // An unknown level counts as off, so it can never pass for a high count
  always_ff @(posedge clk)
  begin
    if (clr)
    begin
      n_pwm  <= 0;
      n_dir  <= 0;
      n_up   <= 0;
      n_down <= 0;
    end
    else
    begin
      n_pwm  <= n_pwm + int'(pwm === 1'b1);
      n_dir  <= n_dir + int'(dir === 1'b1);
      n_up   <= n_up + int'(up === 1'b1);
      n_down <= n_down + int'(down === 1'b1);
    end
  end
endmodule

// ===== verif/test_pwg_channel.sv
// Self-checking bench for one PWM/PDM channel: register tasks and duty checks.
// Assumes the stage model counts high clocks of every pin.
`timescale 1ns/1ps

`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fails++; $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end

module test_pwg_channel;
  logic        clk;                  // 40 MHz clock
  logic        rst;                  // Synchronous reset
  logic [3:0]  addr;                 // Register address
  logic [31:0] wdata;                // Write data
  logic        wr;                   // Write strobe
  logic        rd;                   // Read strobe
  logic [31:0] rdata;                // Read data
  logic        pwm, dir, up, down;   // Power stage pins
  logic        clr;                  // Clears model counts
  int          n_pwm, n_dir, n_up, n_down; // High clocks per pin
  int          fails;                // Mismatches
  int          cmp_count;            // Comparisons
  logic [31:0] rst_tab [8] = '{32'h0, 32'h0, 32'h4000, 32'h0, 32'h0, 32'h4000, 32'h3e8, 32'h0};

  pwg_channel i_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
                     .rdata(rdata), .pwm(pwm), .dir(dir), .up(up), .down(down));
  pwg_stage_model i_stage (.clk(clk), .clr(clr), .pwm(pwm), .dir(dir), .up(up), .down(down),
                           .n_pwm(n_pwm), .n_dir(n_dir), .n_up(n_up), .n_down(n_down));

  // One-cycle write, then an idle clock so strobes never collide
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  // One-cycle read; data stands only in the following cycle
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask

  // Set command, carrier and control, then outlast one update step
  task automatic go(input logic [3:0] c, input logic [31:0] f, input logic [15:0] v);
    wr_reg(4'h1, {{16{v[15]}}, v});
    wr_reg(4'h6, f);
    wr_reg(4'h0, {28'h0, c});
    rd_chk(4'h0, {28'h0, c});
    repeat (4300) @(posedge clk);
  endtask

  // Count high clocks over a window of whole carrier periods
  task automatic meas(input int n, input int ep, input int ed, input int eu, input int edn);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (n) @(posedge clk);
    #1;
    `CHK(n_pwm, ep)
    `CHK(n_dir, ed)
    `CHK(n_up, eu)
    `CHK(n_down, edn)
  endtask

  task automatic print_verdict;
    if (fails == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Clock generator
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Watchdog: the run needs about 95000 clocks
  initial
  begin
    repeat (101000) @(posedge clk);
    fails++;
    print_verdict();
  end

  // Main sequence; duty figures assume a 4-tick carrier unless noted
  initial
  begin
    {rst, addr, wdata, wr, rd, clr, fails, cmp_count} = '0;
    rst = 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 8; i++)
      rd_chk(4'(i), rst_tab[i]);
    rd_chk(4'hf, 32'h0);
    wr_reg(4'h1, 32'h0000c000);
    rd_chk(4'h1, 32'hffffc000);
    wr_reg(4'h2, 32'h2000); // Scale 0.5, so 16'h1000 gives half duty
    go(4'h1, 250000, 16'h1000);
    rd_chk(4'h7, 32'h2000);
    rd_chk(4'h8, 32'h4);
    // Reset carrier of 1000 ticks must end before fresh counts are taken
    repeat (35900) @(posedge clk);
    meas(640, 320, 0, 0, 0);
    go(4'h5, 250000, 16'hf000);
    rd_chk(4'h7, 32'hffffe000);
    meas(640, 320, 640, 0, 0);
    go(4'h9, 250000, 16'hf000);
    meas(640, 0, 0, 0, 320);
    go(4'h9, 250000, 16'h1000);
    meas(640, 0, 0, 320, 0);
    wr_reg(4'h4, 32'h1000); // Floor a quarter
    go(4'h1, 250000, 16'hf000);
    rd_chk(4'h7, 32'hfffff000);
    meas(640, 160, 0, 0, 0);
    wr_reg(4'h5, 32'h3000); // Ceiling three quarters
    go(4'h1, 250000, 16'h2000);
    rd_chk(4'h7, 32'h3000);
    meas(640, 480, 0, 0, 0);
    wr_reg(4'h3, 32'h2000); // Offset alone gives half duty
    go(4'h1, 250000, 16'h0000);
    meas(640, 320, 0, 0, 0);
    wr_reg(4'h3, 32'h0);
    go(4'h1, 1000000, 16'h1000);
    rd_chk(4'h8, 32'h2);
    meas(640, 320, 0, 0, 0);
    go(4'h1, 300000, 16'h0800);
    rd_chk(4'h8, 32'h3);
    meas(480, 160, 0, 0, 0);
    go(4'h3, 300000, 16'h1000);
    meas(480, 240, 0, 0, 0);
    go(4'h3, 0, 16'h0800);
    rd_chk(4'h8, 32'h0);
    meas(640, 160, 0, 0, 0);
    go(4'h0, 250000, 16'h1000);
    meas(640, 0, 0, 0, 0);
    print_verdict();
  end
endmodule
